//--- rtl/spm_pkg.sv
// constants shared by the serial port pin multiplexer
package spm_pkg;
    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int AW = 8;
    localparam int DW = 32;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_PCR = 8'h00; // pin_control_reg
    localparam logic [7:0] OFS_SPC = 8'h04; // serial_port_control_reg
    localparam logic [7:0] OFS_TXD = 8'h08; // transmit word
    localparam logic [7:0] OFS_RXD = 8'h0c; // received bits

    // ------------------------------------------------------------
    // pin_control_reg fields
    // ------------------------------------------------------------
    localparam int PCR_RX_DIR  = 0; // rx_clock_direction
    localparam int PCR_TX_DIR  = 1; // tx_clock_direction
    localparam int PCR_RX_GPIO = 2; // rx_gpio_select
    localparam int PCR_TX_GPIO = 3; // tx_gpio_select
    localparam int PCR_RXC_VAL = 4; // gpio level, rx clock pin
    localparam int PCR_TXC_VAL = 5; // gpio level, tx clock pin
    localparam int PCR_TXD_VAL = 6; // gpio level, tx data pin
    localparam int PCR_RXC_OUT = 7; // gpio drive, rx clock pin
    localparam int PCR_TXC_OUT = 8; // gpio drive, tx clock pin
    localparam int PCR_W       = 9;
    localparam logic [8:0] PCR_RST = 9'h000;

    // ------------------------------------------------------------
    // serial_port_control_reg fields (read only)
    // ------------------------------------------------------------
    localparam int SPC_TXC_LVL = 0; // tx_clock_level_status
    localparam int SPC_RXC_LVL = 1;
    localparam int SPC_RXD_LVL = 2;
    localparam int SPC_OFF_LVL = 3;
    localparam int SPC_W       = 4;

    // ------------------------------------------------------------
    // data words, responses, timing
    // ------------------------------------------------------------
    localparam int WORD_W = 8;
    localparam logic [7:0] TXD_RST = 8'h00;
    localparam logic [2:0] TX_IDX_TOP = 3'h7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [2:0] LINK_DIV_LAST = 3'h3; // half period - 1
    localparam int LK_N = 15; // levels synchronised into link side
    localparam int SY_N = 7;  // levels synchronised into system side
endpackage

//--- rtl/spm_sync.sv
// three stage synchroniser with agreement filter
`timescale 1ns/1ps
module spm_sync (
    // clock
    input  wire logic clk,
    // level in and filtered level out
    input  wire logic d,
    output logic      q
);
    logic s1_q, s2_q, s3_q, q_q;
    logic q_d;

    // output follows once stages two and three agree
    always_comb begin
        q_d = q_q;
        if (s2_q == s3_q) begin
            q_d = s3_q;
        end
    end

    // stage registers, first stage feeds only the second
    always_ff @(posedge clk) begin
        s1_q <= d;
        s2_q <= s1_q;
        s3_q <= s2_q;
        q_q  <= q_d;
    end

    assign q = q_q;
endmodule // spm_sync

//--- rtl/spm_pin_mux.sv
// serial port pin multiplexer with axi4-lite registers
// What this block does
// RQ1 - rx clock pin shifts receiver data
// RQ2 - rx gpio select frees rx pins
// RQ3 - rx clock direction bit drives rx clock
// RQ4 - tx clock pin shifts out transmit data
// RQ5 - tx clock direction zero makes pin input
// RQ6 - tx clock level readable in status register
// RQ7 - tx gpio select frees tx pins
// RQ8 - tx data output only, rx data input
// RQ9 - global off input tristates clock, data pins
//
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module spm_pin_mux (
    // system clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    // link clock
    input  wire logic                  clk_link,
    // axi4-lite write address
    input  wire logic [spm_pkg::AW-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    // axi4-lite write data
    input  wire logic [spm_pkg::DW-1:0] s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // axi4-lite read address
    input  wire logic [spm_pkg::AW-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    // axi4-lite read data
    output logic [spm_pkg::DW-1:0]     s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // global tri-state control, low floats the pins
    input  wire logic                  off_n,
    // receive pins
    input  wire logic                  rx_shift_clock_pin_i,
    output logic                       rx_shift_clock_pin_o,
    output logic                       rx_shift_clock_pin_oe,
    input  wire logic                  rx_serial_data_pin_i,
    // transmit pins
    input  wire logic                  tx_shift_clock_pin_i,
    output logic                       tx_shift_clock_pin_o,
    output logic                       tx_shift_clock_pin_oe,
    output logic                       tx_serial_data_pin_o,
    output logic                       tx_serial_data_pin_oe
);
    import spm_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [LK_N-1:0] lk_raw, lk_s;
    logic [SY_N-1:0] sy_raw, sy_s;
    logic [PCR_W-1:0] pcr_q, pcr_d, l_pcr;
    logic [WORD_W-1:0] txw_q, txw_d, rxw_q, rxw_d;
    logic [SPC_W-1:0] st_q, st_d;
    logic [2:0] idx_q, idx_d;
    logic tx_bit_q, tx_bit_d, rx_seen_q, rx_seen_d, tx_seen_q, tx_seen_d;
    logic [1:0] rx_dly_q, rx_dly_d;
    logic l_off, l_rxc, l_txc, l_rxd, l_rst, l_tx_bit;
    logic [2:0] div_q, div_d;
    logic gclk_q, gclk_d, rxc_prev_q, rxc_prev_d, txc_prev_q, txc_prev_d;
    logic rx_bit_q, rx_bit_d, rx_tgl_q, rx_tgl_d;
    logic txd_q, txd_d, tx_tgl_q, tx_tgl_d;
    logic rxc_o_q, rxc_o_d, rxc_oe_q, rxc_oe_d;
    logic txc_o_q, txc_o_d, txc_oe_q, txc_oe_d;
    logic txd_o_q, txd_o_d, txd_oe_q, txd_oe_d;
    logic rx_rise, tx_fall;
    logic [AW-1:0] aw_addr_q, aw_addr_d;
    logic [DW-1:0] w_data_q, w_data_d, rdata_q, rdata_d;
    logic [3:0] w_strb_q, w_strb_d;
    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic awready_q, awready_d, wready_q, wready_d;
    logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic wr_fire;

    // address decode shared by write and read paths
    function automatic logic reg_hit(input logic [AW-1:0] a,
                                     input logic wr);
        logic hit;
        hit = (a == OFS_PCR) || (a == OFS_TXD);
        if (!wr) begin
            hit = hit || (a == OFS_SPC) || (a == OFS_RXD);
        end
        return hit;
    endfunction

    // ------------------------------------------------------------
    // clock domain crossings
    // ------------------------------------------------------------
    assign lk_raw = {pcr_q, tx_bit_q, rst, rx_serial_data_pin_i,
                     tx_shift_clock_pin_i, rx_shift_clock_pin_i, off_n};
    assign sy_raw = {rx_bit_q, tx_tgl_q, rx_tgl_q, l_off, l_rxd,
                     l_rxc, l_txc};
    assign {l_pcr, l_tx_bit, l_rst, l_rxd, l_txc, l_rxc, l_off} = lk_s;

    // pins and system levels into the link domain
    for (genvar i = 0; i < LK_N; i++) begin : g_lk
        spm_sync u_sync (
            .clk (clk_link),
            .d   (lk_raw[i]),
            .q   (lk_s[i])
        );
    end

    // link state back into the system domain
    for (genvar i = 0; i < SY_N; i++) begin : g_sy
        spm_sync u_sync (
            .clk (clk_sys),
            .d   (sy_raw[i]),
            .q   (sy_s[i])
        );
    end

    // ------------------------------------------------------------
    // link domain: clock divider, shifting and pin drivers
    // ------------------------------------------------------------
    assign rx_rise = l_rxc && !rxc_prev_q;
    assign tx_fall = !l_txc && txc_prev_q;

    // next state of the link side
    always_comb begin
        div_d = div_q + 3'h1;
        gclk_d = gclk_q;
        if (div_q == LINK_DIV_LAST) begin
            div_d = 3'h0;
            gclk_d = !gclk_q;
        end
        rxc_prev_d = l_rxc;
        txc_prev_d = l_txc;
        rx_bit_d = rx_bit_q;
        rx_tgl_d = rx_tgl_q;
        txd_d = txd_q;
        tx_tgl_d = tx_tgl_q;
        // receiver samples data on rising rx clock edge
        if (rx_rise && !l_pcr[PCR_RX_GPIO]) begin // see RQ1 see RQ2
            rx_bit_d = l_rxd;
            rx_tgl_d = !rx_tgl_q;
        end
        // transmitter launches next bit on falling tx clock edge
        if (tx_fall && !l_pcr[PCR_TX_GPIO]) begin // see RQ4 see RQ7
            txd_d = l_tx_bit;
            tx_tgl_d = !tx_tgl_q;
        end
        rxc_o_d = l_pcr[PCR_RX_GPIO] ? l_pcr[PCR_RXC_VAL] : gclk_q;
        rxc_oe_d = l_off && (l_pcr[PCR_RX_GPIO] ? l_pcr[PCR_RXC_OUT]
            : l_pcr[PCR_RX_DIR]); // see RQ3 see RQ9
        txc_o_d = l_pcr[PCR_TX_GPIO] ? l_pcr[PCR_TXC_VAL] : gclk_q;
        txc_oe_d = l_off && (l_pcr[PCR_TX_GPIO] ? l_pcr[PCR_TXC_OUT]
            : l_pcr[PCR_TX_DIR]); // see RQ5 see RQ9
        txd_o_d = l_pcr[PCR_TX_GPIO] ? l_pcr[PCR_TXD_VAL] : txd_d; // see RQ8
        txd_oe_d = l_off; // see RQ8 see RQ9
        if (l_rst) begin
            div_d = 3'h0;
            gclk_d = 1'b0;
            rx_bit_d = 1'b0;
            rx_tgl_d = 1'b0;
            txd_d = 1'b0;
            tx_tgl_d = 1'b0;
            rxc_o_d = 1'b0;
            rxc_oe_d = 1'b0;
            txc_o_d = 1'b0;
            txc_oe_d = 1'b0;
            txd_o_d = 1'b0;
            txd_oe_d = 1'b0;
        end
    end

    // link side registers
    always_ff @(posedge clk_link) begin
        div_q <= div_d;
        gclk_q <= gclk_d;
        rxc_prev_q <= rxc_prev_d;
        txc_prev_q <= txc_prev_d;
        rx_bit_q <= rx_bit_d;
        rx_tgl_q <= rx_tgl_d;
        txd_q <= txd_d;
        tx_tgl_q <= tx_tgl_d;
        rxc_o_q <= rxc_o_d;
        rxc_oe_q <= rxc_oe_d;
        txc_o_q <= txc_o_d;
        txc_oe_q <= txc_oe_d;
        txd_o_q <= txd_o_d;
        txd_oe_q <= txd_oe_d;
    end

    assign rx_shift_clock_pin_o  = rxc_o_q;
    assign rx_shift_clock_pin_oe = rxc_oe_q;
    assign tx_shift_clock_pin_o  = txc_o_q;
    assign tx_shift_clock_pin_oe = txc_oe_q;
    assign tx_serial_data_pin_o  = txd_o_q;
    assign tx_serial_data_pin_oe = txd_oe_q;

    // ------------------------------------------------------------
    // system domain: registers, word assembly, status
    // ------------------------------------------------------------
    // rx events wait two cycles so the bit level has settled too
    always_comb begin
        pcr_d = pcr_q;
        txw_d = txw_q;
        idx_d = idx_q;
        rxw_d = rxw_q;
        rx_seen_d = sy_s[4];
        tx_seen_d = sy_s[5];
        rx_dly_d = {rx_dly_q[0], sy_s[4] != rx_seen_q};
        if (rx_dly_q[1]) begin
            rxw_d = {rxw_q[WORD_W-2:0], sy_s[6]};
        end
        if (sy_s[5] != tx_seen_q) begin
            idx_d = idx_q - 3'h1;
        end
        if (wr_fire && aw_addr_q == OFS_PCR) begin
            if (w_strb_q[0]) begin
                pcr_d[7:0] = w_data_q[7:0];
            end
            if (w_strb_q[1]) begin
                pcr_d[8] = w_data_q[8];
            end
        end
        if (wr_fire && aw_addr_q == OFS_TXD && w_strb_q[0]) begin
            txw_d = w_data_q[WORD_W-1:0];
            idx_d = TX_IDX_TOP;
        end
        tx_bit_d = txw_d[idx_d];
        st_d = {sy_s[3], sy_s[2], sy_s[1], sy_s[0]}; // see RQ6
        if (rst) begin
            pcr_d = PCR_RST;
            txw_d = TXD_RST;
            idx_d = TX_IDX_TOP;
            rxw_d = 8'h00;
            tx_bit_d = 1'b0;
            rx_dly_d = 2'h0;
        end
    end

    // system side registers
    always_ff @(posedge clk_sys) begin
        pcr_q <= pcr_d;
        txw_q <= txw_d;
        idx_q <= idx_d;
        rxw_q <= rxw_d;
        tx_bit_q <= tx_bit_d;
        rx_seen_q <= rx_seen_d;
        tx_seen_q <= tx_seen_d;
        rx_dly_q <= rx_dly_d;
        st_q <= st_d;
    end

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;

    // channel handshakes, write commit and read mux
    always_comb begin
        aw_addr_d = aw_addr_q;
        w_data_d = w_data_q;
        w_strb_d = w_strb_q;
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        if (s_axi_awvalid && awready_q) begin
            aw_have_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q) begin
            w_have_d = 1'b1;
            w_data_d = s_axi_wdata;
            w_strb_d = s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (wr_fire) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = reg_hit(aw_addr_q, 1'b1) ? RESP_OKAY : RESP_SLVERR;
        end
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rresp_d = reg_hit(s_axi_araddr, 1'b0) ? RESP_OKAY : RESP_SLVERR;
            case (s_axi_araddr)
                OFS_PCR: rdata_d = {23'h0, pcr_q};
                OFS_SPC: rdata_d = {28'h0, st_q}; // see RQ6
                OFS_TXD: rdata_d = {24'h0, txw_q};
                OFS_RXD: rdata_d = {24'h0, rxw_q};
                default: rdata_d = 32'h0;
            endcase
        end
        awready_d = !aw_have_d && !bvalid_d;
        wready_d = !w_have_d && !bvalid_d;
        arready_d = !rvalid_d;
        if (rst) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b0;
            rvalid_d = 1'b0;
            awready_d = 1'b0;
            wready_d = 1'b0;
            arready_d = 1'b0;
            bresp_d = RESP_OKAY;
            rresp_d = RESP_OKAY;
            rdata_d = 32'h0;
        end
    end

    // bus registers
    always_ff @(posedge clk_sys) begin
        aw_addr_q <= aw_addr_d;
        w_data_q <= w_data_d;
        w_strb_q <= w_strb_d;
        aw_have_q <= aw_have_d;
        w_have_q <= w_have_d;
        awready_q <= awready_d;
        wready_q <= wready_d;
        bvalid_q <= bvalid_d;
        bresp_q <= bresp_d;
        arready_q <= arready_d;
        rvalid_q <= rvalid_d;
        rresp_q <= rresp_d;
        rdata_q <= rdata_d;
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_rx_capture: assert property ( // see RQ1
        @(posedge clk_link) disable iff (l_rst)
        rx_rise && !l_pcr[PCR_RX_GPIO] |=>
            rx_bit_q == $past(l_rxd) && rx_tgl_q != $past(rx_tgl_q))
        else $error("rx bit not captured on rx clock rise");
    a_rx_gpio_quiet: assert property ( // see RQ2
        @(posedge clk_link) disable iff (l_rst)
        l_pcr[PCR_RX_GPIO] |=> $stable(rx_tgl_q))
        else $error("receiver shifted while rx pins are gpio");
    a_rxc_drive: assert property ( // see RQ3
        @(posedge clk_link) disable iff (l_rst)
        l_off && !l_pcr[PCR_RX_GPIO] |=> rxc_oe_q == $past(l_pcr[PCR_RX_DIR]))
        else $error("rx clock direction not followed");
    a_tx_shift: assert property ( // see RQ4
        @(posedge clk_link) disable iff (l_rst)
        tx_fall && !l_pcr[PCR_TX_GPIO] |=>
            txd_o_q == $past(l_tx_bit) && tx_tgl_q != $past(tx_tgl_q))
        else $error("tx bit not launched on tx clock fall");
    a_txc_input: assert property ( // see RQ5
        @(posedge clk_link) disable iff (l_rst)
        !l_pcr[PCR_TX_GPIO] && !l_pcr[PCR_TX_DIR] |=> !txc_oe_q)
        else $error("tx clock pin driven while set as input");
    a_tx_level: assert property ( // see RQ6
        @(posedge clk_sys) disable iff (rst)
        s_axi_arvalid && arready_q && s_axi_araddr == OFS_SPC |=>
            s_axi_rvalid && s_axi_rdata[SPC_TXC_LVL] == $past(st_q[0]))
        else $error("status read lost tx clock level");
    a_tx_gpio_val: assert property ( // see RQ7
        @(posedge clk_link) disable iff (l_rst)
        l_pcr[PCR_TX_GPIO] |=> txd_o_q == $past(l_pcr[PCR_TXD_VAL])
            && $stable(tx_tgl_q))
        else $error("tx data pin not following gpio level");
    a_txd_serial: assert property ( // see RQ8
        @(posedge clk_link) disable iff (l_rst)
        !l_pcr[PCR_TX_GPIO] ##1 !l_pcr[PCR_TX_GPIO] |-> txd_o_q == txd_q)
        else $error("tx data pin not carrying serial bit");
    a_off_float: assert property ( // see RQ9
        @(posedge clk_link) disable iff (l_rst)
        !l_off |=> !rxc_oe_q && !txc_oe_q && !txd_oe_q)
        else $error("pins driven while off is low");
    c_rx_bit: cover property (@(posedge clk_link) disable iff (l_rst)
        rx_rise && !l_pcr[PCR_RX_GPIO]);
    c_tx_bit: cover property (@(posedge clk_link) disable iff (l_rst)
        tx_fall && !l_pcr[PCR_TX_GPIO]);
    c_pcr_write: cover property (@(posedge clk_sys) disable iff (rst)
        wr_fire && aw_addr_q == OFS_PCR);
endmodule // spm_pin_mux

//--- verif/spm_peer.sv
// external serial device model: shift clock, rx data, tx capture
`timescale 1ns/1ps
module spm_peer #(
    parameter int HALF_NS = 1000
) (
    // frame start and word to send
    input  wire logic       go,
    input  wire logic [7:0] word_in,
    // tx data as seen on the wire
    input  wire logic       tx_dat,
    // clock drive and level, rx data
    output logic            clk_drv,
    output logic            clk_lvl,
    output logic            rx_dat,
    // captured tx word and end of frame
    output logic [7:0]      word_out,
    output logic            done
);
    // -----------------------------------------------------------
    // idle: clock released, pull-up holds it high
    // -----------------------------------------------------------
    initial begin
        clk_drv  = 1'b0;
        clk_lvl  = 1'b1;
        rx_dat   = 1'b0;
        word_out = 8'h00;
        done     = 1'b0;
    end

    // -----------------------------------------------------------
    // one frame of eight bits, msb first, edges 1 us apart
    // -----------------------------------------------------------
    always @(posedge go) begin
        done    = 1'b0;
        clk_drv = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            clk_lvl  = 1'b0;       // fall: device launches next bit
            rx_dat   = word_in[i];
            #(HALF_NS);
            clk_lvl  = 1'b1;       // rise: both sides sample
            word_out = {word_out[6:0], tx_dat};
            #(HALF_NS);
        end
        clk_drv = 1'b0;
        rx_dat  = ~rx_dat;         // released line shows no stale bit
        done    = 1'b1;
    end
endmodule // spm_peer

//--- verif/spm_tb.sv
// self-checking testbench for the serial port pin multiplexer
`timescale 1ns/1ps
module serial_port_pin_mux_test;
    import spm_pkg::*;
    // -----------------------------------------------------------
    // stimulus and observed signals
    // -----------------------------------------------------------
    logic        clk_sys = 0, clk_link = 0, rst = 1, off_n = 1;
    logic [7:0]  awaddr = 0, araddr = 0, p_word = 0, p_out;
    logic [31:0] wdata = 0, rdata, dat;
    logic [3:0]  wstrb = 0;
    logic        awvalid = 0, wvalid = 0, bready = 0;
    logic        arvalid = 0, rready = 0, tx_lvl = 1, p_go = 0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, rsp;
    logic        rxc_i, rxc_o, rxc_oe, rxd_i, txc_i, txc_o, txc_oe;
    logic        txd_o, txd_oe, p_drv, p_clk, p_done;
    int          failures = 0, comparisons = 0;

    always #50 clk_sys = ~clk_sys;
    initial begin
        #3.7;
        forever #6 clk_link = ~clk_link;
    end

    // wire levels: device drive, else peer, else pull-up or bench
    assign rxc_i = rxc_oe ? rxc_o : (p_drv ? p_clk : 1'b1);
    assign txc_i = txc_oe ? txc_o : (p_drv ? p_clk : tx_lvl);

    spm_pin_mux i_dut (
        .clk_sys(clk_sys), .rst(rst), .clk_link(clk_link),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .off_n(off_n),
        .rx_shift_clock_pin_i(rxc_i), .rx_shift_clock_pin_o(rxc_o),
        .rx_shift_clock_pin_oe(rxc_oe), .rx_serial_data_pin_i(rxd_i),
        .tx_shift_clock_pin_i(txc_i), .tx_shift_clock_pin_o(txc_o),
        .tx_shift_clock_pin_oe(txc_oe), .tx_serial_data_pin_o(txd_o),
        .tx_serial_data_pin_oe(txd_oe)
    );

    spm_peer #(.HALF_NS(1000)) i_peer (
        .go(p_go), .word_in(p_word), .tx_dat(txd_o),
        .clk_drv(p_drv), .clk_lvl(p_clk), .rx_dat(rxd_i),
        .word_out(p_out), .done(p_done)
    );

    // -----------------------------------------------------------
    // bus tasks and checking
    // -----------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        @(posedge clk_sys);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wstrb   <= 4'hf;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge clk_sys);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask

    // let a config write reach the link-side pins
    task automatic settle();
        repeat (4) @(posedge clk_sys);
    endtask

    // one peer frame, then time for rx bits to cross back
    task automatic frame(input logic [7:0] w);
        @(posedge clk_sys);
        p_word <= w;
        p_go   <= 1'b1;
        @(posedge clk_sys);
        p_go <= 1'b0;
        while (!p_done) @(posedge clk_sys);
        repeat (20) @(posedge clk_sys);
    endtask

    task automatic close_out();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // -----------------------------------------------------------
    // test sequence
    // -----------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        settle();
        // register map, read-only and unmapped places
        rd(OFS_PCR, dat, rsp);
        chk("pcr reset", dat, {23'h0, PCR_RST});
        chk("pcr resp", {30'h0, rsp}, {30'h0, RESP_OKAY});
        rd(OFS_TXD, dat, rsp);
        chk("txd reset", dat, {24'h0, TXD_RST});
        wr(OFS_SPC, 32'hf, rsp);
        chk("spc write resp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
        rd(8'h10, dat, rsp);
        chk("unmapped data", dat, 32'h0);
        chk("unmapped resp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
        wr(OFS_PCR, 32'h1ff, rsp);
        chk("pcr write resp", {30'h0, rsp}, {30'h0, RESP_OKAY});
        rd(OFS_PCR, dat, rsp);
        chk("pcr readback", dat, 32'h1ff);
        $display("test registers finished");
        // clock pin directions
        wr(OFS_PCR, 32'h1, rsp);
        settle();
        chk("oe rx drive", {29'h0, rxc_oe, txc_oe, txd_oe}, 32'h5);
        wr(OFS_PCR, 32'h2, rsp);
        settle();
        chk("oe tx drive", {29'h0, rxc_oe, txc_oe, txd_oe}, 32'h3);
        // global off floats clocks and tx data
        wr(OFS_PCR, 32'h3, rsp);
        off_n <= 1'b0;
        settle();
        chk("oe off", {29'h0, rxc_oe, txc_oe, txd_oe}, 32'h0);
        off_n <= 1'b1;
        settle();
        chk("oe on", {29'h0, rxc_oe, txc_oe, txd_oe}, 32'h7);
        $display("test directions finished");
        // tx clock level seen by software
        wr(OFS_PCR, 32'h0, rsp);
        tx_lvl <= 1'b0;
        settle();
        rd(OFS_SPC, dat, rsp);
        chk("tx level low", {31'h0, dat[SPC_TXC_LVL]}, 32'h0);
        tx_lvl <= 1'b1;
        settle();
        rd(OFS_SPC, dat, rsp);
        chk("tx level high", {31'h0, dat[SPC_TXC_LVL]}, 32'h1);
        // gpio mode on both sides, pins follow register bits
        wr(OFS_PCR, 32'h1dc, rsp);
        settle();
        chk("gpio pins a", {26'h0, rxc_oe, rxc_o, txc_oe, txc_o, txd_oe,
            txd_o}, 32'h3b);
        rd(OFS_SPC, dat, rsp);
        chk("gpio tx level", {31'h0, dat[SPC_TXC_LVL]}, 32'h0);
        wr(OFS_PCR, 32'h1ac, rsp);
        settle();
        chk("gpio pins b", {26'h0, rxc_oe, rxc_o, txc_oe, txc_o, txd_oe,
            txd_o}, 32'h2e);
        $display("test levels finished");
        // serial frames back to back, msb first both ways
        wr(OFS_PCR, 32'h0, rsp);
        wr(OFS_TXD, 32'ha5, rsp);
        rd(OFS_TXD, dat, rsp);
        chk("txd readback", dat, 32'ha5);
        frame(8'h3c);
        chk("tx word 1", {24'h0, p_out}, 32'ha5);
        rd(OFS_RXD, dat, rsp);
        chk("rx word 1", dat, 32'h3c);
        wr(OFS_TXD, 32'h5a, rsp);
        frame(8'hc3);
        chk("tx word 2", {24'h0, p_out}, 32'h5a);
        rd(OFS_RXD, dat, rsp);
        chk("rx word 2", dat, 32'hc3);
        // gpio mode stops shifting on both sides
        wr(OFS_PCR, 32'hc, rsp);
        frame(8'h0f);
        chk("gpio tx word", {24'h0, p_out}, 32'h0);
        rd(OFS_RXD, dat, rsp);
        chk("gpio rx word", dat, 32'hc3);
        $display("test frames finished");
        close_out();
    end

    // watchdog against a hung handshake
    initial begin
        repeat (3000) @(posedge clk_sys);
        failures++;
        close_out();
    end
endmodule // serial_port_pin_mux_test
